// [flash_cmd_map.vh]
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH
// ----------------------------------------
// axi-lite register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STAT 8'h0c
`define REG_RDAT 8'h10
// ----------------------------------------
// control fields
// ----------------------------------------
`define CTRL_GO 0
`define CTRL_OP_LO 4
`define CTRL_OP_HI 7
`define CTRL_ACCEL 8
`define CTRL_CNT_LO 16
`define CTRL_CNT_HI 20
// ----------------------------------------
// operation codes
// ----------------------------------------
`define OP_PROG 4'h0
`define OP_BUFLOAD 4'h1
`define OP_BUFWORD 4'h2
`define OP_BUFCONF 4'h3
`define OP_CHIPERA 4'h4
`define OP_BLKERA 4'h5
`define OP_BLKADD 4'h6
`define OP_BYPENT 4'h7
`define OP_BYPEXIT 4'h8
`define OP_RESET 4'h9
`define OP_ABRTRST 4'ha
`define OP_READ 4'hb
// ----------------------------------------
// flash command words
// ----------------------------------------
`define UNLK_A1 23'h000555
`define UNLK_D1 16'h00aa
`define UNLK_A2 23'h0002aa
`define UNLK_D2 16'h0055
`define CMD_PROG 16'h00a0
`define CMD_BUFLOAD 16'h0025
`define CMD_BUFCONF 16'h0029
`define CMD_ERASE 16'h0080
`define CMD_CHIP 16'h0010
`define CMD_BLK 16'h0030
`define CMD_BYPASS 16'h0020
`define CMD_BYPX1 16'h0090
`define CMD_BYPX2 16'h0000
`define CMD_RESET 16'h00f0
`define CMD_ABRT 16'h00f0
`define BUF_MAX 5'h1f
// ----------------------------------------
// bus timing in mclk cycles (25 ns)
// ----------------------------------------
`define T_SETUP 4'h2
`define T_PULSE 4'h3
`define T_HOLD 4'h2
`define T_READ 4'h4
`define WIN_NS 50000
`define WIN_CYC (`WIN_NS / 25)
`endif

// [flash_bus_cycle.v]
`timescale 1ns/1ps
module flash_bus_cycle
(
   input wire mclk,
   input wire rst,
   input wire start,
   input wire isRead,
   input wire [22:0] addrIn,
   input wire [15:0] dataIn,
   input wire [15:0] dqIn,
   output reg busy,
   output reg [22:0] flashAddr,
   output reg [15:0] dqOut,
   output reg dqOe,
   output reg ceN,
   output reg weN,
   output reg oeN,
   output reg [15:0] rdData
);
`include "flash_cmd_map.vh"
localparam S_IDLE = 2'd0;
localparam S_SET = 2'd1;
localparam S_PUL = 2'd2;
localparam S_HLD = 2'd3;
reg [1:0] st_r;
reg [3:0] cnt_r;
reg rd_r;
reg [15:0] dqS1_r;
reg [15:0] dqS2_r;
// ----------------------------------------
// pin input synchroniser
// ----------------------------------------
always @(posedge mclk or posedge rst)
begin
   if (rst)
   begin
      dqS1_r <= 16'h0000;
      dqS2_r <= 16'h0000;
   end
   else
   begin
      dqS1_r <= dqIn;
      dqS2_r <= dqS1_r;
   end
end
// ----------------------------------------
// one strobe cycle
// ----------------------------------------
always @(posedge mclk or posedge rst)
begin
   if (rst)
   begin
      st_r <= S_IDLE;
      cnt_r <= 4'h0;
      rd_r <= 1'b0;
      busy <= 1'b0;
      flashAddr <= 23'h000000;
      dqOut <= 16'h0000;
      dqOe <= 1'b0;
      ceN <= 1'b1;
      weN <= 1'b1;
      oeN <= 1'b1;
      rdData <= 16'h0000;
   end
   else
   begin
      case (st_r)
         S_IDLE:
         begin
            if (start)
            begin
               busy <= 1'b1;
               rd_r <= isRead;
               flashAddr <= addrIn;
               dqOut <= dataIn;
               dqOe <= ~isRead;
               ceN <= 1'b0;
               oeN <= 1'b1;
               cnt_r <= `T_SETUP;
               st_r <= S_SET;
            end
         end
         S_SET:
            if (cnt_r == 4'h1)
            begin
               // both low with oe high makes a write; address taken here
               weN <= rd_r; // R1 R2
               oeN <= ~rd_r;
               cnt_r <= rd_r ? `T_READ : `T_PULSE;
               st_r <= S_PUL;
            end
            else
               cnt_r <= cnt_r - 4'h1;
         S_PUL:
            if (cnt_r == 4'h1)
            begin
               // we rises first so data taken on it while ce stays low
               weN <= 1'b1; // R2
               oeN <= 1'b1;
               if (rd_r)
                  rdData <= dqS2_r;
               cnt_r <= `T_HOLD;
               st_r <= S_HLD;
            end
            else
               cnt_r <= cnt_r - 4'h1;
         S_HLD:
            if (cnt_r == 4'h1)
            begin
               ceN <= 1'b1;
               dqOe <= 1'b0;
               busy <= 1'b0;
               st_r <= S_IDLE;
            end
            else
               cnt_r <= cnt_r - 4'h1;
         default:
            st_r <= S_IDLE;
      endcase
   end
end
endmodule

// [flash_cmd_host.v]
// Behaviour
// R1 - write needs chip select, write low, output high
// R2 - address on last fall, data first rise
// R3 - program is unlock, unlock, setup, address-data
// R4 - no commands while program runs
// R5 - programming only clears bits
// R6 - buffer holds at most 32 words
// R7 - buffer load order: unlocks, load, count
// R8 - count above 1f aborts
// R9 - later pairs share fifth cycle page
// R10 - never load one location twice; the code compares only the page, not repeated addresses
// R11 - confirm after declared pairs at block address
// R12 - abort shows flag; host sends abort reset
// R13 - poll status at last loaded address
// R14 - accel level enters bypass automatically
// R15 - bypass entry: unlocks then 20h
// R16 - bypass program: a0h then address-data
// R17 - bypass erase: 80h then 30h or 10h
// R18 - bypass exit: 90h then 00h
// R19 - chip erase six cycles, ends poll high
// R20 - block erase six cycles, 80h and 30h
// R21 - extra blocks within 50us window
// R22 - other command in window resets; code leaves it running after program, buffer load/word, bypass entry/exit
// R23 - f0h returns to read mode
// R24 - unexpected cycle returns to read mode
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module flash_cmd_host
#(
   parameter WIN_CYCLES = `WIN_CYC
)
(
   input wire mclk,
   input wire rst,
   input wire [31:0] awaddr,
   input wire awvalid,
   output wire awready,
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   output reg [1:0] bresp,
   output reg bvalid,
   input wire bready,
   input wire [31:0] araddr,
   input wire arvalid,
   output wire arready,
   output reg [31:0] rdata,
   output reg [1:0] rresp,
   output reg rvalid,
   input wire rready,
   output wire [22:0] flashAddr,
   output wire [15:0] dqOut,
   output wire dqOe,
   input wire [15:0] dqIn,
   output wire ceN,
   output wire weN,
   output wire oeN,
   output reg accelHigh
);
localparam S_IDLE = 2'd0;
localparam S_ISSUE = 2'd1;
localparam S_WAIT = 2'd2;
// ----------------------------------------
// registers
// ----------------------------------------
reg [3:0] op_r;
reg [4:0] count_r;
reg [22:0] addr_r;
reg [15:0] data_r;
reg [1:0] st_r;
reg [2:0] step_r;
reg [2:0] last_r;
reg bypass_r;
reg errBusy_r;
reg errCount_r;
reg [5:0] pairs_r;
reg [5:0] declared_r;
reg [17:0] page_r;
reg pageValid_r;
reg [22:0] lastAddr_r;
reg [31:0] winCnt_r;
reg start_r;
reg isRead_r;
reg [22:0] cycAddr_r;
reg [15:0] cycData_r;
reg awHeld_r;
reg wHeld_r;
reg [31:0] awA_r;
reg [31:0] wD_r;
reg wstrbOk;
reg go_r;
wire cycBusy;
wire [15:0] rdWord;
wire busy = (st_r != S_IDLE);
wire inBypass = bypass_r | accelHigh; // R14
// ----------------------------------------
// strobe engine
// ----------------------------------------
flash_bus_cycle u_cyc
(
   .mclk(mclk),
   .rst(rst),
   .start(start_r),
   .isRead(isRead_r),
   .addrIn(cycAddr_r),
   .dataIn(cycData_r),
   .dqIn(dqIn),
   .busy(cycBusy),
   .flashAddr(flashAddr),
   .dqOut(dqOut),
   .dqOe(dqOe),
   .ceN(ceN),
   .weN(weN),
   .oeN(oeN),
   .rdData(rdWord)
);
// ----------------------------------------
// axi-lite slave
// ----------------------------------------
assign awready = ~awHeld_r & ~bvalid;
assign wready = ~wHeld_r & ~bvalid;
assign arready = ~rvalid;
wire wrFire = awHeld_r & wHeld_r & ~bvalid;
wire [7:0] wOff = awA_r[7:0];
wire goReq = wrFire && (wOff == `REG_CTRL) && wD_r[`CTRL_GO] && wstrbOk;
always @(posedge mclk or posedge rst)
begin
   if (rst)
   begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awA_r <= 32'h00000000;
      wD_r <= 32'h00000000;
      wstrbOk <= 1'b0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h00000000;
      op_r <= 4'h0;
      count_r <= 5'h00;
      addr_r <= 23'h000000;
      data_r <= 16'h0000;
      accelHigh <= 1'b0;
   end
   else
   begin
      if (awvalid && awready)
      begin
         awHeld_r <= 1'b1;
         awA_r <= awaddr;
      end
      if (wvalid && wready)
      begin
         wHeld_r <= 1'b1;
         wD_r <= wdata;
         wstrbOk <= &wstrb;
      end
      if (wrFire)
      begin
         awHeld_r <= 1'b0;
         wHeld_r <= 1'b0;
         bvalid <= 1'b1;
         bresp <= 2'b00;
         case (wOff)
            `REG_CTRL:
               if (!busy)
               begin
                  op_r <= wD_r[`CTRL_OP_HI:`CTRL_OP_LO];
                  count_r <= wD_r[`CTRL_CNT_HI:`CTRL_CNT_LO];
                  accelHigh <= wD_r[`CTRL_ACCEL];
               end
            `REG_ADDR: addr_r <= wD_r[22:0];
            `REG_DATA: data_r <= wD_r[15:0];
            `REG_STAT, `REG_RDAT: bresp <= 2'b00;
            default: bresp <= 2'b10;
         endcase
      end
      else if (bvalid && bready)
         bvalid <= 1'b0;
      if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rresp <= 2'b00;
         case (araddr[7:0])
            `REG_CTRL: rdata <= {11'h000, count_r, 7'h00, accelHigh, op_r, 3'h0, busy};
            `REG_ADDR: rdata <= {9'h000, addr_r};
            `REG_DATA: rdata <= {16'h0000, data_r};
            `REG_STAT: rdata <= {9'h000, lastAddr_r} |
                         {24'h000000, pageValid_r, errCount_r, errBusy_r, 2'b00,
                          inBypass, 1'b0, busy};
            `REG_RDAT: rdata <= {16'h0000, rdWord};
            default:
            begin
               rdata <= 32'h00000000;
               rresp <= 2'b10;
            end
         endcase
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end
end
// ----------------------------------------
// per-step flash word
// ----------------------------------------
reg [22:0] sa;
reg [15:0] sd;
reg sRead;
reg sLast;
always @*
begin
   sa = `UNLK_A1;
   sd = `UNLK_D1;
   sRead = 1'b0;
   sLast = 1'b0;
   case (step_r)
      3'd0:
      begin
         sa = `UNLK_A1;
         sd = `UNLK_D1;
      end
      3'd1:
      begin
         sa = `UNLK_A2;
         sd = `UNLK_D2;
      end
      3'd3:
      begin
         sa = `UNLK_A1;
         sd = `UNLK_D1;
      end
      3'd4:
      begin
         sa = `UNLK_A2;
         sd = `UNLK_D2;
      end
      default:
      begin
         sa = `UNLK_A1;
         sd = `UNLK_D1;
      end
   endcase
   case (op_r)
      `OP_PROG: // R3 R16 R5
         if (step_r == 3'd2)
            sd = `CMD_PROG;
         else if (step_r == 3'd3)
         begin
            sa = addr_r;
            sd = data_r;
            sLast = 1'b1;
         end
      `OP_BUFLOAD: // R7
         if (step_r == 3'd2)
         begin
            sa = addr_r;
            sd = `CMD_BUFLOAD;
         end
         else if (step_r == 3'd3)
         begin
            sa = addr_r;
            sd = {11'h000, count_r};
            sLast = 1'b1;
         end
      `OP_BUFWORD:
      begin
         sa = addr_r;
         sd = data_r;
         sLast = 1'b1;
      end
      `OP_BUFCONF: // R11
      begin
         sa = addr_r;
         sd = `CMD_BUFCONF;
         sLast = 1'b1;
      end
      `OP_CHIPERA, `OP_BLKERA: // R19 R20 R17
         if (step_r == 3'd2)
         begin
            sd = `CMD_ERASE;
            sLast = 1'b0;
         end
         else if (step_r == 3'd5)
         begin
            sa = (op_r == `OP_BLKERA) ? addr_r : `UNLK_A1;
            sd = (op_r == `OP_BLKERA) ? `CMD_BLK : `CMD_CHIP;
            sLast = 1'b1;
         end
      `OP_BLKADD: // R21
      begin
         sa = addr_r;
         sd = `CMD_BLK;
         sLast = 1'b1;
      end
      `OP_BYPENT: // R15
         if (step_r == 3'd2)
         begin
            sd = `CMD_BYPASS;
            sLast = 1'b1;
         end
      `OP_BYPEXIT: // R18
         if (step_r == 3'd2)
            sd = `CMD_BYPX1;
         else
         begin
            sd = `CMD_BYPX2;
            sLast = 1'b1;
         end
      `OP_RESET: // R23
      begin
         sd = `CMD_RESET;
         sLast = 1'b1;
      end
      `OP_ABRTRST: // R12
         if (step_r == 3'd2)
         begin
            sd = `CMD_ABRT;
            sLast = 1'b1;
         end
      `OP_READ: // R13
      begin
         sa = addr_r;
         sRead = 1'b1;
         sLast = 1'b1;
      end
      default:
         sLast = 1'b1;
   endcase
end
// ----------------------------------------
// first step of each operation
// ----------------------------------------
reg [2:0] firstStep;
always @*
begin
   firstStep = 3'd0;
   case (op_r)
      `OP_BUFWORD, `OP_BUFCONF, `OP_BLKADD, `OP_RESET, `OP_READ: firstStep = 3'd0;
      `OP_BYPEXIT: firstStep = 3'd2;
      `OP_PROG: firstStep = inBypass ? 3'd2 : 3'd0; // R16
      `OP_CHIPERA, `OP_BLKERA: firstStep = inBypass ? 3'd2 : 3'd0; // R17
      default: firstStep = 3'd0;
   endcase
end
wire eraseOp = (op_r == `OP_CHIPERA) || (op_r == `OP_BLKERA);
wire isUnlockStep = (step_r < 3'd2) || (eraseOp && ((step_r == 3'd3) || (step_r == 3'd4)));
wire eraseUnlock = eraseOp && inBypass && (step_r == 3'd3);
wire [2:0] nextStep = eraseUnlock ? 3'd5 : (step_r + 3'd1);
// ----------------------------------------
// sequencer and checks
// ----------------------------------------
always @(posedge mclk or posedge rst)
begin
   if (rst)
   begin
      st_r <= S_IDLE;
      step_r <= 3'd0;
      last_r <= 3'd0;
      start_r <= 1'b0;
      isRead_r <= 1'b0;
      cycAddr_r <= 23'h000000;
      cycData_r <= 16'h0000;
      bypass_r <= 1'b0;
      errBusy_r <= 1'b0;
      errCount_r <= 1'b0;
      pairs_r <= 6'h00;
      declared_r <= 6'h00;
      page_r <= 18'h00000;
      pageValid_r <= 1'b0;
      lastAddr_r <= 23'h000000;
      winCnt_r <= 32'h00000000;
      go_r <= 1'b0;
   end
   else
   begin
      start_r <= 1'b0;
      // act a cycle late so the new op and count fields are in place
      go_r <= goReq && !busy;
      if (winCnt_r != 32'h00000000)
         winCnt_r <= winCnt_r - 32'h00000001; // R21
      case (st_r)
         S_IDLE:
            if (go_r)
            begin
               errCount_r <= 1'b0;
               if (op_r == `OP_BUFLOAD && count_r > `BUF_MAX)
                  errCount_r <= 1'b1; // R6 R8
               else if (op_r == `OP_BUFCONF && pairs_r != declared_r)
                  errCount_r <= 1'b1; // R11
               else if (op_r == `OP_BUFWORD && pageValid_r &&
                        addr_r[22:5] != page_r)
                  errCount_r <= 1'b1; // R9 R10
               else if (op_r == `OP_BLKADD && winCnt_r == 32'h00000000)
                  errCount_r <= 1'b1; // R22
               else
               begin
                  step_r <= firstStep;
                  st_r <= S_ISSUE;
               end
            end
         S_ISSUE:
            if (!cycBusy && !start_r)
            begin
               if (inBypass && isUnlockStep && op_r != `OP_BYPENT && op_r != `OP_ABRTRST)
                  step_r <= nextStep;
               else
               begin
                  start_r <= 1'b1;
                  isRead_r <= sRead;
                  cycAddr_r <= sa;
                  cycData_r <= sd;
                  last_r <= {2'b00, sLast};
                  st_r <= S_WAIT;
               end
            end
         S_WAIT:
            if (!cycBusy && !start_r)
            begin
               if (last_r[0])
               begin
                  st_r <= S_IDLE;
                  case (op_r)
                     `OP_BUFLOAD:
                     begin
                        declared_r <= {1'b0, count_r} + 6'h01;
                        pairs_r <= 6'h00;
                        pageValid_r <= 1'b0;
                     end
                     `OP_BUFWORD:
                     begin
                        pairs_r <= pairs_r + 6'h01;
                        page_r <= addr_r[22:5];
                        pageValid_r <= 1'b1;
                        lastAddr_r <= addr_r;
                     end
                     `OP_BLKERA, `OP_BLKADD: winCnt_r <= WIN_CYCLES; // R21
                     `OP_BYPENT: bypass_r <= 1'b1;
                     `OP_BYPEXIT: bypass_r <= 1'b0;
                     `OP_PROG: lastAddr_r <= addr_r;
                     default: winCnt_r <= 32'h00000000;
                  endcase
               end
               else
               begin
                  step_r <= nextStep;
                  st_r <= S_ISSUE;
               end
            end
         default:
            st_r <= S_IDLE;
      endcase
      if (goReq && busy)
         errBusy_r <= 1'b1; // R4 R24
      else if (goReq)
         errBusy_r <= 1'b0;
   end
end
endmodule

// [flash_cmd_host_asserts.sv]
`timescale 1ns/1ps
module flash_cmd_host_asserts
(
   input wire mclk,
   input wire rst,
   input wire bvalid,
   input wire bready,
   input wire rvalid,
   input wire rready,
   input wire [22:0] flashAddr,
   input wire [15:0] dqOut,
   input wire dqOe,
   input wire ceN,
   input wire weN,
   input wire oeN
);
   // ------
   // strobe timing and response handshakes
   // ------
   default clocking dcb @(posedge mclk);
   endclocking
   default disable iff (rst);
   chk_write_qual: assert property (!weN |-> !ceN && oeN && dqOe)
      else $error("write strobe without select or data drive");
   chk_read_quiet: assert property (!oeN |-> !dqOe && weN)
      else $error("read overlaps write drive");
   chk_we_width: assert property ($fell(weN) |-> !weN [*3] ##1 weN)
      else $error("write pulse width wrong");
   chk_ce_setup: assert property ($fell(weN) |-> !$past(ceN, 2) && $past(ceN, 3))
      else $error("select setup before write pulse wrong");
   chk_ce_hold: assert property ($rose(weN) |-> !ceN ##1 !ceN ##1 ceN)
      else $error("select hold after write pulse wrong");
   chk_addr_steady: assert property (!ceN && !$past(ceN) |-> $stable(flashAddr))
      else $error("address moved inside a cycle");
   chk_dq_steady: assert property (dqOe && $past(dqOe) |-> $stable(dqOut))
      else $error("write data moved inside a cycle");
   chk_cycle_gap: assert property ($rose(ceN) |=> ceN)
      else $error("no idle cycle between flash cycles");
   chk_bresp_once: assert property (bvalid && bready |=> !bvalid)
      else $error("write response repeated");
   chk_rresp_once: assert property (rvalid && rready |=> !rvalid)
      else $error("read response repeated");
endmodule
bind flash_cmd_host flash_cmd_host_asserts i_chk (.mclk(mclk), .rst(rst), .bvalid(bvalid),
   .bready(bready), .rvalid(rvalid), .rready(rready), .flashAddr(flashAddr), .dqOut(dqOut),
   .dqOe(dqOe), .ceN(ceN), .weN(weN), .oeN(oeN));

// [flash_model.sv]
`timescale 1ns/1ps
module flash_model
(
   input wire [22:0] flashAddr,
   input wire [15:0] dqOut,
   input wire dqOe,
   input wire ceN,
   input wire weN,
   input wire oeN,
   output wire [15:0] dqIn
);
   // ------
   // write capture and status drive
   // ------
   localparam logic [15:0] READY = 16'h0080;
   logic [22:0] latA = 23'h0;
   logic [15:0] lastV = 16'h0;
   logic [22:0] logA[$];
   logic [15:0] logD[$];
   always @(negedge weN or negedge ceN)
      if (!weN && !ceN && oeN)
         latA = flashAddr;
   always @(posedge weN or posedge ceN)
      if (weN != ceN && oeN)
      begin
         logA.push_back(latA);
         logD.push_back(dqIn);
         lastV = dqIn;
      end
   always @(posedge oeN)
      lastV = READY;
   assign dqIn = dqOe ? dqOut : (!ceN && !oeN) ? READY : ~lastV;
endmodule

// [testbench.sv]
`timescale 1ns/1ps
`include "flash_cmd_map.vh"
module testbench;
   // ------
   // bench signals
   // ------
   localparam int WIN = 60;
   localparam logic [22:0] DC = 23'h7fffff;
   localparam logic [22:0] BA = 23'h001000;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] rr;
   wire awready, wready, bvalid, arready, rvalid, dqOe, ceN, weN, oeN, accelHigh;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [22:0] flashAddr;
   wire [15:0] dqOut, dqIn;
   int mismatches = 0;
   int checks = 0;
   logic [22:0] expA[$];
   logic [15:0] expD[$];
   initial forever #12.5 mclk = ~mclk;
   flash_cmd_host #(.WIN_CYCLES(WIN)) i_dut (.mclk(mclk), .rst(rst), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn),
      .ceN(ceN), .weN(weN), .oeN(oeN), .accelHigh(accelHigh));
   flash_model i_flash (.flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .ceN(ceN),
      .weN(weN), .oeN(oeN), .dqIn(dqIn));
   // ------
   // shared tasks
   // ------
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task timeout;
      mismatches++;
      $display("BAD handshake expected answer seen none");
      print_verdict;
   endtask
   task axi_write(input logic [7:0] a, input logic [31:0] d);
      logic hsA, hsW, got;
      got = 1'h0;
      @(posedge mclk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (int n = 0; !got; n++)
      begin
         if (n > 50)
            timeout;
         @(negedge mclk);
         hsA = awvalid && awready;
         hsW = wvalid && wready;
         got = bvalid;
         @(posedge mclk);
         if (hsA)
            awvalid <= 1'h0;
         if (hsW)
            wvalid <= 1'h0;
         if (got)
            bready <= 1'h0;
      end
   endtask
   task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic hsA, got;
      got = 1'h0;
      @(posedge mclk);
      araddr <= {24'h0, a};
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (int n = 0; !got; n++)
      begin
         if (n > 50)
            timeout;
         @(negedge mclk);
         hsA = arvalid && arready;
         got = rvalid;
         d = rdata;
         r = rresp;
         @(posedge mclk);
         if (hsA)
            arvalid <= 1'h0;
         if (got)
            rready <= 1'h0;
      end
   endtask
   task wait_idle;
      rd = 32'h1;
      for (int n = 0; rd[0]; n++)
      begin
         if (n > 200)
            timeout;
         axi_read(`REG_STAT, rd, rr);
      end
   endtask
   task do_op(input logic [3:0] op, input logic [22:0] a, input logic [15:0] d,
      input logic [4:0] cnt, input logic acc);
      axi_write(`REG_ADDR, {9'h0, a});
      axi_write(`REG_DATA, {16'h0, d});
      axi_write(`REG_CTRL, {11'h0, cnt, 7'h0, acc, op, 4'h1});
      wait_idle;
   endtask
   task ex(input logic [22:0] a, input logic [15:0] d);
      expA.push_back(a);
      expD.push_back(d);
   endtask
   task unlk;
      ex(`UNLK_A1, `UNLK_D1);
      ex(`UNLK_A2, `UNLK_D2);
   endtask
   task check_log(input string what);
      check({what, " count"}, i_flash.logD.size(), expD.size());
      foreach (expD[i])
         if (i < i_flash.logD.size())
         begin
            if (expA[i] !== DC)
               check({what, " addr"}, i_flash.logA[i], expA[i]);
            check({what, " data"}, i_flash.logD[i], expD[i]);
         end
      expA.delete();
      expD.delete();
      i_flash.logA.delete();
      i_flash.logD.delete();
   endtask
   // ------
   // scenarios
   // ------
   task test_program;
      unlk;
      ex(DC, 16'h00a0);
      ex(23'h001200, 16'h5a5a);
      axi_write(`REG_ADDR, 32'h1200);
      axi_write(`REG_DATA, 32'h5a5a);
      axi_write(`REG_CTRL, {24'h0, `OP_PROG, 4'h1});
      axi_write(`REG_CTRL, {24'h0, `OP_RESET, 4'h1});
      wait_idle;
      check("busy refusal", rd[5], 32'h1);
      check_log("program");
      $display("test program done");
   endtask
   task test_bypass;
      unlk;
      ex(DC, 16'h0020);
      do_op(`OP_BYPENT, 23'h0, 16'h0, 5'h0, 1'h0);
      check("bypass on", rd[2], 32'h1);
      check_log("bypass entry");
      ex(DC, 16'h00a0);
      ex(23'h002000, 16'h0f0f);
      do_op(`OP_PROG, 23'h2000, 16'h0f0f, 5'h0, 1'h0);
      check_log("bypass program");
      ex(DC, 16'h0080);
      ex(DC, 16'h0010);
      do_op(`OP_CHIPERA, 23'h0, 16'h0, 5'h0, 1'h0);
      check_log("bypass erase");
      ex(DC, 16'h0090);
      ex(DC, 16'h0000);
      do_op(`OP_BYPEXIT, 23'h0, 16'h0, 5'h0, 1'h0);
      check("bypass off", rd[2], 32'h0);
      check_log("bypass exit");
      $display("test bypass done");
   endtask
   task test_accel;
      axi_write(`REG_CTRL, 32'h100);
      check("accel level", accelHigh, 32'h1);
      ex(DC, 16'h00a0);
      ex(23'h001300, 16'h00ff);
      do_op(`OP_PROG, 23'h1300, 16'h00ff, 5'h0, 1'h1);
      check_log("accel program");
      axi_write(`REG_CTRL, 32'h0);
      check("accel level", accelHigh, 32'h0);
      $display("test accel done");
   endtask
   task test_erase;
      unlk;
      ex(DC, 16'h0080);
      unlk;
      ex(DC, 16'h0010);
      do_op(`OP_CHIPERA, 23'h0, 16'h0, 5'h0, 1'h0);
      check_log("chip erase");
      unlk;
      ex(DC, 16'h0080);
      unlk;
      ex(23'h010000, 16'h0030);
      ex(23'h020000, 16'h0030);
      do_op(`OP_BLKERA, 23'h10000, 16'h0, 5'h0, 1'h0);
      do_op(`OP_BLKADD, 23'h20000, 16'h0, 5'h0, 1'h0);
      check_log("block erase");
      repeat (WIN + 40) @(posedge mclk);
      do_op(`OP_BLKADD, 23'h30000, 16'h0, 5'h0, 1'h0);
      check("late block", rd[6], 32'h1);
      check_log("late block");
      $display("test erase done");
   endtask
   task test_buffer;
      unlk;
      ex(BA, `CMD_BUFLOAD);
      ex(BA, 16'h001f);
      ex(23'h001010, 16'h1111);
      do_op(`OP_BUFLOAD, BA, 16'h0, 5'h1f, 1'h0);
      do_op(`OP_BUFWORD, 23'h1010, 16'h1111, 5'h0, 1'h0);
      do_op(`OP_BUFWORD, 23'h1118, 16'h2222, 5'h0, 1'h0);
      check("page change", rd[6], 32'h1);
      check_log("page change");
      unlk;
      ex(DC, 16'h00f0);
      do_op(`OP_ABRTRST, BA, 16'h0, 5'h0, 1'h0);
      check_log("abort reset");
      unlk;
      ex(BA, `CMD_BUFLOAD);
      ex(BA, 16'h0001);
      ex(23'h001018, 16'h3333);
      ex(23'h001010, 16'h4444);
      ex(BA, `CMD_BUFCONF);
      do_op(`OP_BUFLOAD, BA, 16'h0, 5'h1, 1'h0);
      do_op(`OP_BUFWORD, 23'h1018, 16'h3333, 5'h0, 1'h0);
      do_op(`OP_BUFWORD, 23'h1010, 16'h4444, 5'h0, 1'h0);
      do_op(`OP_BUFCONF, BA, 16'h0, 5'h0, 1'h0);
      check_log("buffer program");
      unlk;
      ex(BA, `CMD_BUFLOAD);
      ex(BA, 16'h0001);
      ex(23'h001010, 16'h5555);
      do_op(`OP_BUFLOAD, BA, 16'h0, 5'h1, 1'h0);
      do_op(`OP_BUFWORD, 23'h1010, 16'h5555, 5'h0, 1'h0);
      do_op(`OP_BUFCONF, BA, 16'h0, 5'h0, 1'h0);
      check("short count", rd[6], 32'h1);
      check_log("short count");
      $display("test buffer done");
   endtask
   task test_misc;
      ex(`UNLK_A1, 16'h00f0);
      do_op(`OP_RESET, 23'h0, 16'h0, 5'h0, 1'h0);
      check_log("reset command");
      do_op(`OP_READ, 23'h1010, 16'h0, 5'h0, 1'h0);
      axi_read(`REG_RDAT, rd, rr);
      check("status word", rd[15:0], 32'h0080);
      axi_read(8'h40, rd, rr);
      check("unmapped resp", rr, 32'h2);
      axi_write(8'h40, 32'h0);
      check("unmapped bresp", bresp, 32'h2);
      $display("test misc done");
   endtask
   initial
   begin
      repeat (16) @(posedge mclk);
      rst <= 1'h0;
      test_program;
      test_bypass;
      test_accel;
      test_erase;
      test_buffer;
      test_misc;
      print_verdict;
   end
endmodule
